// ===== hdl/cfr_pkg.sv
// Constants shared by the configuration fabric router and the logical sub-core end.
// Assumes one configuration clock for all ends.
package cfr_pkg;
  localparam int          CFR_ADDR_W      = 24;
  localparam int          CFR_DATA_W      = 32;
  localparam int          CFR_STRB_W      = 4;
  localparam logic [1:0]  CFR_RESP_OKAY   = 2'h0;
  localparam logic [1:0]  CFR_RESP_ERR    = 2'h2;
  // Space boundaries (byte offsets)
  localparam logic [23:0] CFR_CAP_LAST    = 24'h00003c;
  localparam logic [23:0] CFR_CSR_LAST    = 24'h0000fc;
  localparam logic [23:0] CFR_EXT_LAST    = 24'h00fffc;
  localparam logic [23:0] CFR_BUF_BASE    = 24'h010000;
  // Capability register offsets
  localparam logic [23:0] CFR_DEV_ID_OFS  = 24'h000000;
  localparam logic [23:0] CFR_DEV_INF_OFS = 24'h000004;
  localparam logic [23:0] CFR_ASM_ID_OFS  = 24'h000008;
  localparam logic [23:0] CFR_ASM_INF_OFS = 24'h00000c;
  localparam logic [23:0] CFR_FEAT_OFS    = 24'h000010;
  localparam logic [23:0] CFR_SWP_OFS     = 24'h000014;
  localparam logic [23:0] CFR_SRC_OFS     = 24'h000018;
  localparam logic [23:0] CFR_DST_OFS     = 24'h00001c;
  // Field positions and default extension pointer
  localparam int          CFR_LARGE_SYS_BIT = 4;
  localparam int          CFR_SWITCH_BIT    = 28;
  localparam logic [15:0] CFR_EXT_PTR_DEF   = 16'h0100;
  // Write shapes of the logical slave
  localparam logic [23:0] CFR_SCRATCH_OFS = 24'h010000;

  typedef enum logic [1:0] {CFR_PORT_LOG, CFR_PORT_BUF, CFR_PORT_PHY} cfr_port_type;
endpackage

// ===== hdl/cfr_axil_if.sv
// AXI4-Lite configuration channel between fabric and one sub-core.
// Assumes both ends share clk.
`timescale 1ns/10ps
interface cfr_axil_if
  import cfr_pkg::*;
(
  input wire logic clk
);
  logic                  awvalid;
  logic                  awready;
  logic [CFR_ADDR_W-1:0] awaddr;
  logic [2:0]            awprot;
  logic                  wvalid;
  logic                  wready;
  logic [CFR_DATA_W-1:0] wdata;
  logic [CFR_STRB_W-1:0] wstrb;
  logic                  bvalid;
  logic                  bready;
  logic [1:0]            bresp;
  logic                  arvalid;
  logic                  arready;
  logic [CFR_ADDR_W-1:0] araddr;
  logic [2:0]            arprot;
  logic                  rvalid;
  logic                  rready;
  logic [1:0]            rresp;
  logic [CFR_DATA_W-1:0] rdata;

  modport master (
    output awvalid, awaddr, awprot, wvalid, wdata, wstrb, bready,
    output arvalid, araddr, arprot, rready,
    input  awready, wready, bvalid, bresp, arready, rvalid, rresp, rdata
  );
  modport slave (
    input  clk, awvalid, awaddr, awprot, wvalid, wdata, wstrb, bready,
    input  arvalid, araddr, arprot, rready,
    output awready, wready, bvalid, bresp, arready, rvalid, rresp, rdata
  );
endinterface

// ===== hdl/cfr_log_slave.sv
// Logical sub-core configuration slave: capability bank and one scratch word.
// Assumes fabric as sole master on port; one access at a time.
`timescale 1ns/10ps
module cfr_log_slave
  import cfr_pkg::*;
#(
  parameter logic [15:0] DEVICE_CODE   = 16'h1234, // Arbitrary value
  parameter logic [15:0] VENDOR_CODE   = 16'h5678, // Arbitrary value
  parameter logic [3:0]  SPEC_LABEL    = 4'h3,     // Arbitrary value
  parameter logic [3:0]  MAJOR_REL     = 4'h7,     // Arbitrary value
  parameter logic [3:0]  MINOR_REL     = 4'h9,     // Arbitrary value
  parameter logic [3:0]  PATCH_LEVEL   = 4'h6,     // Arbitrary value
  parameter logic [15:0] ASM_CODE      = 16'h0000,
  parameter logic [15:0] ASM_VENDOR    = 16'h0000,
  parameter logic [15:0] ASM_REVISION  = 16'h0000,
  parameter logic [15:0] EXT_PTR       = CFR_EXT_PTR_DEF,
  parameter logic        EN_BRIDGE     = 1'b1,
  parameter logic        EN_MEMORY     = 1'b1,
  parameter logic        EN_PROCESSOR  = 1'b0,
  parameter logic        EN_LARGE_SYS  = 1'b0,
  parameter logic [15:0] SRC_OPS       = 16'hfc00,
  parameter logic [15:0] DST_OPS       = 16'hfc00
)
(
  input  wire logic              clk_i,
  input  wire logic              rst_i,
  cfr_axil_if.slave              cfg,
  output logic [CFR_DATA_W-1:0]  scratch_o,
  output logic                   busy_o
);

  typedef struct packed {
    logic                  awready;
    logic                  wready;
    logic                  aw_got;
    logic                  w_got;
    logic [CFR_ADDR_W-1:0] waddr;
    logic [CFR_DATA_W-1:0] wdata;
    logic [CFR_STRB_W-1:0] wstrb;
    logic                  bvalid;
    logic [1:0]            bresp;
    logic                  arready;
    logic                  rvalid;
    logic [1:0]            rresp;
    logic [CFR_DATA_W-1:0] rdata;
    logic [CFR_DATA_W-1:0] scratch;
  } cfr_log_state_type;

  cfr_log_state_type state_reg;
  cfr_log_state_type state_next;

  function automatic logic [CFR_DATA_W-1:0] cap_word(input logic [CFR_ADDR_W-1:0] a);
    logic [CFR_DATA_W-1:0] v;
    v = '0;
    case (a)
      CFR_DEV_ID_OFS:  v = {DEVICE_CODE, VENDOR_CODE};
      CFR_DEV_INF_OFS:
        v = {12'h000, SPEC_LABEL, 4'h0, MAJOR_REL, MINOR_REL, PATCH_LEVEL};
      CFR_ASM_ID_OFS:  v = {ASM_CODE, ASM_VENDOR};
      CFR_ASM_INF_OFS: v = {ASM_REVISION, EXT_PTR};
      CFR_FEAT_OFS:
      begin
        v[31] = EN_BRIDGE;
        v[30] = EN_MEMORY;
        v[29] = EN_PROCESSOR;
        v[CFR_SWITCH_BIT] = 1'b0;
        v[CFR_LARGE_SYS_BIT] = EN_LARGE_SYS;
        v[3] = 1'b1;
        v[2:0] = 3'h1;
      end
      CFR_SWP_OFS:     v = '0;
      CFR_SRC_OFS:     v = {16'h0000, SRC_OPS[15:3], 3'h0};
      CFR_DST_OFS:     v = {16'h0000, DST_OPS[15:3], 3'h0};
      default:         v = '0;
    endcase
    return v;
  endfunction

  always_comb
  begin
    state_next = state_reg;
    state_next.awready = 1'b0;
    state_next.wready = 1'b0;
    state_next.arready = 1'b0;
    if (cfg.awvalid && !state_reg.aw_got && !state_reg.awready && !state_reg.bvalid)
    begin
      state_next.awready = 1'b1;
      state_next.aw_got = 1'b1;
      state_next.waddr = cfg.awaddr;
    end
    if (cfg.wvalid && !state_reg.w_got && !state_reg.wready && !state_reg.bvalid)
    begin
      state_next.wready = 1'b1;
      state_next.w_got = 1'b1;
      state_next.wdata = cfg.wdata;
      state_next.wstrb = cfg.wstrb;
    end
    if (state_reg.aw_got && state_reg.w_got && !state_reg.bvalid)
    begin
      state_next.aw_got = 1'b0;
      state_next.w_got = 1'b0;
      state_next.bvalid = 1'b1;
      state_next.bresp = CFR_RESP_OKAY;
      if (state_reg.waddr == CFR_SCRATCH_OFS)
      begin
        for (int i = 0; i < CFR_STRB_W; i++)
        begin
          if (state_reg.wstrb[i])
            state_next.scratch[8*i +: 8] = state_reg.wdata[8*i +: 8];
        end
      end
      else if (state_reg.waddr > CFR_CAP_LAST)
        state_next.bresp = CFR_RESP_ERR;
      // Capability writes are acknowledged but dropped
    end
    if (state_reg.bvalid && cfg.bready)
      state_next.bvalid = 1'b0;
    if (cfg.arvalid && !state_reg.arready && !state_reg.rvalid)
    begin
      state_next.arready = 1'b1;
      state_next.rvalid = 1'b1;
      state_next.rresp = CFR_RESP_OKAY;
      if (cfg.araddr <= CFR_CAP_LAST)
        state_next.rdata = cap_word(cfg.araddr);
      else if (cfg.araddr == CFR_SCRATCH_OFS)
        state_next.rdata = state_reg.scratch;
      else
      begin
        state_next.rdata = '0;
        state_next.rresp = CFR_RESP_ERR;
      end
    end
    if (state_reg.rvalid && cfg.rready)
      state_next.rvalid = 1'b0;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      state_reg <= '0;
    else
      state_reg <= state_next;
  end

  assign cfg.awready = state_reg.awready;
  assign cfg.wready  = state_reg.wready;
  assign cfg.bvalid  = state_reg.bvalid;
  assign cfg.bresp   = state_reg.bresp;
  assign cfg.arready = state_reg.arready;
  assign cfg.rvalid  = state_reg.rvalid;
  assign cfg.rresp   = state_reg.rresp;
  assign cfg.rdata   = state_reg.rdata;
  assign scratch_o   = state_reg.scratch;
  assign busy_o      = state_reg.bvalid | state_reg.rvalid;
endmodule

// ===== hdl/cfr_fabric.sv
// Configuration fabric: one master port in, three sub-core slave ports out.
// Assumes all ports on clk_i; reset released synchronously.
`timescale 1ns/10ps
////////////////////////////////////////////////////////////////////////////////
module cfr_fabric
  import cfr_pkg::*;
(
  input  wire logic clk_i,
  input  wire logic rst_i,
  cfr_axil_if.slave  mst,
  cfr_axil_if.master log_port,
  cfr_axil_if.master buf_port,
  cfr_axil_if.master phy_port,
  output logic       busy_o,
  output logic [1:0] last_port_o
);

  typedef enum logic [2:0] {CFR_IDLE, CFR_WR_ADDR, CFR_WR_RESP, CFR_WR_RET,
                            CFR_RD_ADDR, CFR_RD_RESP, CFR_RD_RET} cfr_fsm_type;

  typedef struct packed {
    cfr_fsm_type           fsm;
    cfr_port_type          sel;
    logic                  mst_awready;
    logic                  mst_wready;
    logic                  mst_arready;
    logic                  aw_pend;
    logic                  w_pend;
    logic [CFR_ADDR_W-1:0] addr;
    logic [CFR_DATA_W-1:0] wdata;
    logic [CFR_STRB_W-1:0] wstrb;
    logic [1:0]            resp;
    logic [CFR_DATA_W-1:0] rdata;
    logic                  busy;
  } cfr_fab_state_type;

  cfr_fab_state_type state_reg;
  cfr_fab_state_type state_next;

  logic [2:0] sel_awready;
  logic [2:0] sel_wready;
  logic [2:0] sel_bvalid;
  logic [2:0] sel_arready;
  logic [2:0] sel_rvalid;

  function automatic cfr_port_type decode(input logic [CFR_ADDR_W-1:0] a);
    if (a <= CFR_CSR_LAST)
      return CFR_PORT_LOG;
    else if (a <= CFR_EXT_LAST)
      return CFR_PORT_PHY;
    else
      return CFR_PORT_BUF; // Buffer owns implementation space
  endfunction

  // Handshake of all three sub-cores, indexed by sel
  always_comb
  begin
    sel_awready = {phy_port.awready, buf_port.awready, log_port.awready};
    sel_wready  = {phy_port.wready,  buf_port.wready,  log_port.wready};
    sel_bvalid  = {phy_port.bvalid,  buf_port.bvalid,  log_port.bvalid};
    sel_arready = {phy_port.arready, buf_port.arready, log_port.arready};
    sel_rvalid  = {phy_port.rvalid,  buf_port.rvalid,  log_port.rvalid};
  end

  function automatic logic [1:0] clean(input logic [1:0] r);
    return r[0] ? CFR_RESP_ERR : r; // Reserved code never passed on
  endfunction

  always_comb
  begin
    state_next = state_reg;
    state_next.mst_awready = 1'b0;
    state_next.mst_wready = 1'b0;
    state_next.mst_arready = 1'b0;
    case (state_reg.fsm)
      CFR_IDLE:
      begin
        // Write wins a tie; read waits one transaction
        if (mst.awvalid && mst.wvalid)
        begin
          state_next.mst_awready = 1'b1;
          state_next.mst_wready = 1'b1;
          state_next.addr = mst.awaddr;
          state_next.wdata = mst.wdata;
          state_next.wstrb = mst.wstrb;
          state_next.sel = decode(mst.awaddr);
          state_next.aw_pend = 1'b1;
          state_next.w_pend = 1'b1;
          state_next.fsm = CFR_WR_ADDR;
        end
        else if (mst.arvalid && !mst.awvalid)
        begin
          state_next.mst_arready = 1'b1;
          state_next.addr = mst.araddr;
          state_next.sel = decode(mst.araddr);
          state_next.fsm = CFR_RD_ADDR;
        end
      end
      CFR_WR_ADDR:
      begin
        if (sel_awready[state_reg.sel])
          state_next.aw_pend = 1'b0;
        if (sel_wready[state_reg.sel])
          state_next.w_pend = 1'b0;
        if ((!state_reg.aw_pend || sel_awready[state_reg.sel]) &&
            (!state_reg.w_pend || sel_wready[state_reg.sel]))
          state_next.fsm = CFR_WR_RESP;
      end
      CFR_WR_RESP:
      begin
        if (sel_bvalid[state_reg.sel])
        begin
          case (state_reg.sel)
            CFR_PORT_BUF: state_next.resp = clean(buf_port.bresp);
            CFR_PORT_PHY: state_next.resp = clean(phy_port.bresp);
            default:      state_next.resp = clean(log_port.bresp);
          endcase
          state_next.fsm = CFR_WR_RET;
        end
      end
      CFR_WR_RET:
      begin
        if (mst.bready)
          state_next.fsm = CFR_IDLE;
      end
      CFR_RD_ADDR:
      begin
        if (sel_arready[state_reg.sel])
          state_next.fsm = CFR_RD_RESP;
      end
      CFR_RD_RESP:
      begin
        if (sel_rvalid[state_reg.sel])
        begin
          case (state_reg.sel)
            CFR_PORT_BUF:
            begin
              state_next.resp = clean(buf_port.rresp);
              state_next.rdata = buf_port.rdata;
            end
            CFR_PORT_PHY:
            begin
              state_next.resp = clean(phy_port.rresp);
              state_next.rdata = phy_port.rdata;
            end
            default:
            begin
              state_next.resp = clean(log_port.rresp);
              state_next.rdata = log_port.rdata;
            end
          endcase
          state_next.fsm = CFR_RD_RET;
        end
      end
      CFR_RD_RET:
      begin
        if (mst.rready)
          state_next.fsm = CFR_IDLE;
      end
      default: state_next.fsm = CFR_IDLE;
    endcase
    state_next.busy = (state_next.fsm != CFR_IDLE);
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      state_reg <= '0;
    else
      state_reg <= state_next;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Master port answers
  assign mst.awready = state_reg.mst_awready;
  assign mst.wready  = state_reg.mst_wready;
  assign mst.arready = state_reg.mst_arready;
  assign mst.bvalid  = (state_reg.fsm == CFR_WR_RET);
  assign mst.bresp   = state_reg.resp;
  assign mst.rvalid  = (state_reg.fsm == CFR_RD_RET);
  assign mst.rresp   = state_reg.resp;
  assign mst.rdata   = state_reg.rdata;
  assign busy_o      = state_reg.busy;
  assign last_port_o = state_reg.sel;

  ////////////////////////////////////////////////////////////////////////////
  // Slave ports: shared address/data, per-port valids
  assign log_port.awaddr  = state_reg.addr;
  assign buf_port.awaddr  = state_reg.addr;
  assign phy_port.awaddr  = state_reg.addr;
  assign log_port.araddr  = state_reg.addr;
  assign buf_port.araddr  = state_reg.addr;
  assign phy_port.araddr  = state_reg.addr;
  assign log_port.wdata   = state_reg.wdata;
  assign buf_port.wdata   = state_reg.wdata;
  assign phy_port.wdata   = state_reg.wdata;
  assign log_port.wstrb   = state_reg.wstrb;
  assign buf_port.wstrb   = state_reg.wstrb;
  assign phy_port.wstrb   = state_reg.wstrb;
  assign log_port.awprot  = 3'h0;
  assign buf_port.awprot  = 3'h0;
  assign phy_port.awprot  = 3'h0;
  assign log_port.arprot  = 3'h0;
  assign buf_port.arprot  = 3'h0;
  assign phy_port.arprot  = 3'h0;

  assign log_port.awvalid = (state_reg.fsm == CFR_WR_ADDR) && state_reg.aw_pend &&
                            (state_reg.sel == CFR_PORT_LOG);
  assign buf_port.awvalid = (state_reg.fsm == CFR_WR_ADDR) && state_reg.aw_pend &&
                            (state_reg.sel == CFR_PORT_BUF);
  assign phy_port.awvalid = (state_reg.fsm == CFR_WR_ADDR) && state_reg.aw_pend &&
                            (state_reg.sel == CFR_PORT_PHY);
  assign log_port.wvalid  = (state_reg.fsm == CFR_WR_ADDR) && state_reg.w_pend &&
                            (state_reg.sel == CFR_PORT_LOG);
  assign buf_port.wvalid  = (state_reg.fsm == CFR_WR_ADDR) && state_reg.w_pend &&
                            (state_reg.sel == CFR_PORT_BUF);
  assign phy_port.wvalid  = (state_reg.fsm == CFR_WR_ADDR) && state_reg.w_pend &&
                            (state_reg.sel == CFR_PORT_PHY);
  assign log_port.bready  = (state_reg.fsm == CFR_WR_RESP) && (state_reg.sel == CFR_PORT_LOG);
  assign buf_port.bready  = (state_reg.fsm == CFR_WR_RESP) && (state_reg.sel == CFR_PORT_BUF);
  assign phy_port.bready  = (state_reg.fsm == CFR_WR_RESP) && (state_reg.sel == CFR_PORT_PHY);
  assign log_port.arvalid = (state_reg.fsm == CFR_RD_ADDR) && (state_reg.sel == CFR_PORT_LOG);
  assign buf_port.arvalid = (state_reg.fsm == CFR_RD_ADDR) && (state_reg.sel == CFR_PORT_BUF);
  assign phy_port.arvalid = (state_reg.fsm == CFR_RD_ADDR) && (state_reg.sel == CFR_PORT_PHY);
  assign log_port.rready  = (state_reg.fsm == CFR_RD_RESP) && (state_reg.sel == CFR_PORT_LOG);
  assign buf_port.rready  = (state_reg.fsm == CFR_RD_RESP) && (state_reg.sel == CFR_PORT_BUF);
  assign phy_port.rready  = (state_reg.fsm == CFR_RD_RESP) && (state_reg.sel == CFR_PORT_PHY);
endmodule

// ===== testbench/cfr_fabric_sva.sv
// Checker for the channel between the fabric and the logical sub-core.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/10ps
module cfr_fabric_sva
  import cfr_pkg::*;
(
  input wire logic                  clk,
  input wire logic                  rst_i,
  input wire logic                  awvalid,
  input wire logic                  awready,
  input wire logic [CFR_ADDR_W-1:0] awaddr,
  input wire logic                  wvalid,
  input wire logic                  wready,
  input wire logic [CFR_DATA_W-1:0] wdata,
  input wire logic [CFR_STRB_W-1:0] wstrb,
  input wire logic                  bvalid,
  input wire logic                  bready,
  input wire logic [1:0]            bresp,
  input wire logic                  arvalid,
  input wire logic                  arready,
  input wire logic [CFR_ADDR_W-1:0] araddr,
  input wire logic                  rvalid,
  input wire logic                  rready,
  input wire logic [1:0]            rresp
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst_i);
  AST_BRESP_CODE: assert property (bvalid |-> !bresp[0])
    else $error("Reserved write response code");
  AST_RRESP_CODE: assert property (rvalid |-> !rresp[0])
    else $error("Reserved read response code");
  AST_AW_HOLD: assert property (awvalid && !awready |=> awvalid && $stable(awaddr))
    else $error("Write address dropped before accept");
  AST_W_HOLD: assert property (wvalid && !wready |=> wvalid && $stable({wdata, wstrb}))
    else $error("Write data dropped before accept");
  AST_AR_HOLD: assert property (arvalid && !arready |=> arvalid && $stable(araddr))
    else $error("Read address dropped before accept");
  AST_B_HOLD: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
    else $error("Write response dropped before accept");
  AST_SINGLE: assert property ((awvalid || wvalid || bvalid) |-> !(arvalid || rvalid))
    else $error("Read and write overlap on one port");
  AST_B_ANSWER: assert property ($rose(awvalid) |-> ##[1:8] bvalid)
    else $error("Write not answered in time");
  AST_R_ANSWER: assert property ($rose(arvalid) |-> ##[1:8] rvalid)
    else $error("Read not answered in time");
  cover property (awvalid && awready && wvalid && wready);
  cover property (bvalid && bready);
  cover property (rvalid && rready);
endmodule

// ===== testbench/cfr_tb_resp.sv
// Sub-core stand-in for the buffer and physical ports.
// Assumes the fabric as master; drives at the falling edge.
`timescale 1ns/10ps
module cfr_tb_resp
  import cfr_pkg::*;
(
  cfr_axil_if.slave       s,
  input  wire logic [1:0] tag_i,
  output logic [31:0]     wdata_o,
  output logic [3:0]      wstrb_o
);
  int          seed = 36;
  logic        hs_w, hs_r, hs_b, hs_d, busy;
  logic [23:0] addr;
  initial
  begin
    {s.awready, s.wready, s.arready, s.bvalid, s.rvalid, s.bresp, s.rresp, s.rdata} = '0;
    {hs_w, hs_r, hs_b, hs_d, busy} = '0;
  end
  always @(posedge s.clk)
  begin
    hs_w <= s.awvalid && s.awready && s.wvalid && s.wready;
    hs_r <= s.arvalid && s.arready;
    hs_b <= s.bvalid && s.bready;
    hs_d <= s.rvalid && s.rready;
    if (s.awvalid && s.awready)
    begin
      addr <= s.awaddr;
      wdata_o <= s.wdata;
      wstrb_o <= s.wstrb;
    end
    if (s.arvalid && s.arready)
      addr <= s.araddr;
  end
  always @(negedge s.clk)
  begin
    if (hs_b || hs_d)
    begin
      {s.bvalid, s.rvalid, busy} <= '0;
      // Stale data flips so it is never mistaken for a fresh answer
      s.rdata <= ~s.rdata;
    end
    // Reserved codes sent on purpose, fabric must clean them
    if (hs_w)
    begin
      s.bvalid <= 1'b1;
      s.bresp <= addr[5:4];
    end
    if (hs_r)
    begin
      s.rvalid <= 1'b1;
      s.rresp <= addr[5:4];
      s.rdata <= {tag_i, 6'h0, addr};
    end
    if (!busy && ($random(seed) & 1) && (s.awvalid || s.arvalid))
    begin
      {s.awready, s.wready, s.arready} <= {s.awvalid, s.awvalid, !s.awvalid};
      busy <= 1'b1;
    end
    else
      {s.awready, s.wready, s.arready} <= '0;
  end
endmodule

// ===== testbench/cfr_fabric_tb_top.sv
// Bench for the fabric joined to the logical sub-core end.
// Assumes one 40 MHz clock shared by all ports.
`timescale 1ns/10ps
module cfr_fabric_tb_top
  import cfr_pkg::*;
;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        busy_o, lbusy;
  logic [1:0]  last_port_o, rs;
  logic [31:0] bdata, pdata, rd, r;
  logic [3:0]  bstrb, pstrb;
  logic [23:0] a;
  logic [1:0]  buf_tag = 2'h1, phy_tag = 2'h2;
  logic [23:0] edges [4] = '{24'h000100, 24'h00fffc, 24'h010000, 24'hfffffc};
  int          seed = 36;
  int          mismatches = 0;
  int          samples_checked = 0;
  // One clock for every port
  cfr_axil_if m_if (.clk(clk_i));
  cfr_axil_if l_if (.clk(clk_i));
  cfr_axil_if b_if (.clk(clk_i));
  cfr_axil_if p_if (.clk(clk_i));
  cfr_fabric u_cfr_fabric (.clk_i(clk_i), .rst_i(rst_i), .mst(m_if), .log_port(l_if),
    .buf_port(b_if), .phy_port(p_if), .busy_o(busy_o), .last_port_o(last_port_o));
  // Arbitrary identity values
  cfr_log_slave #(.DEVICE_CODE(16'h4c2d), .VENDOR_CODE(16'h7a19), .EN_LARGE_SYS(1'b1),
    .ASM_CODE(16'h2468), .ASM_REVISION(16'h0042))
    u_cfr_log_slave (.clk_i(clk_i), .rst_i(rst_i), .cfg(l_if), .scratch_o(), .busy_o(lbusy));
  cfr_tb_resp u_cfr_tb_resp_buf (.s(b_if), .tag_i(buf_tag), .wdata_o(bdata), .wstrb_o(bstrb));
  cfr_tb_resp u_cfr_tb_resp_phy (.s(p_if), .tag_i(phy_tag), .wdata_o(pdata), .wstrb_o(pstrb));
  cfr_fabric_sva u_cfr_fabric_sva (.clk(clk_i), .rst_i(rst_i),
    .awvalid(l_if.awvalid), .awready(l_if.awready), .awaddr(l_if.awaddr),
    .wvalid(l_if.wvalid), .wready(l_if.wready), .wdata(l_if.wdata), .wstrb(l_if.wstrb),
    .bvalid(l_if.bvalid), .bready(l_if.bready), .bresp(l_if.bresp),
    .arvalid(l_if.arvalid), .arready(l_if.arready), .araddr(l_if.araddr),
    .rvalid(l_if.rvalid), .rready(l_if.rready), .rresp(l_if.rresp));
  initial
  begin
    forever #12.5 clk_i = ~clk_i;
  end
  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic [33:0] exp_rd(input logic [23:0] x);
    case (x)
      24'h000000: return {2'h0, 32'h4c2d7a19};
      24'h000004: return {2'h0, 32'h00030796};
      24'h000008: return {2'h0, 32'h24680000};
      24'h00000c: return {2'h0, 32'h00420100};
      24'h000010: return {2'h0, 32'hc0000019};
      24'h000018, 24'h00001c: return {2'h0, 32'h0000fc00};
      default: ;
    endcase
    if (x <= 24'h00003c)
      return 34'h0;
    if (x <= 24'h0000fc)
      return {CFR_RESP_ERR, 32'h0};
    return {(|x[5:4]) ? CFR_RESP_ERR : CFR_RESP_OKAY, (x < 24'h010000) ? 2'h2 : 2'h1, 6'h0, x};
  endfunction
  function automatic logic [1:0] port_of(input logic [23:0] x);
    return (x <= 24'h0000fc) ? 2'h0 : (x < 24'h010000) ? 2'h2 : 2'h1;
  endfunction
  task automatic results();
    if (mismatches == 0 && samples_checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      mismatches++;
      $display("MISMATCH %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic chk2(input logic [1:0] got, input logic [1:0] exp);
    chk32({30'h0, got}, {30'h0, exp});
  endtask
  task automatic wait_for(input int sel);
    int n;
    n = 0;
    do
    begin
      @(posedge clk_i);
      n++;
      if (n > 200)
      begin
        mismatches++;
        results();
      end
    end
    while (!(sel == 0 && m_if.awready === 1'b1 || sel == 1 && m_if.arready === 1'b1 ||
             sel == 2 && m_if.bvalid === 1'b1 || sel == 3 && m_if.rvalid === 1'b1));
  endtask
  task automatic xfer(input logic w, input logic [23:0] x, input logic [31:0] d,
                      input logic [3:0] s);
    logic [33:0] e;
    e = exp_rd(x);
    @(negedge clk_i);
    {m_if.awaddr, m_if.araddr, m_if.wdata, m_if.wstrb} = {x, x, d, s};
    {m_if.awvalid, m_if.wvalid, m_if.arvalid} = {w, w, !w};
    wait_for(w ? 0 : 1);
    chk2({1'b0, busy_o}, 2'h1);
    @(negedge clk_i);
    {m_if.awvalid, m_if.wvalid, m_if.arvalid} = '0;
    wait_for(w ? 2 : 3);
    // Master stalls so the response has to stand
    repeat (1 + ($random(seed) & 3)) @(negedge clk_i);
    {m_if.bready, m_if.rready} = {w, !w};
    @(posedge clk_i);
    {rs, rd} = w ? {m_if.bresp, 32'h0} : {m_if.rresp, m_if.rdata};
    @(negedge clk_i);
    {m_if.bready, m_if.rready} = '0;
    chk2(rs, e[33:32]);
    chk2(last_port_o, port_of(x));
    if (!w)
      chk32(rd, e[31:0]);
    if (w && port_of(x) != 2'h0)
    begin
      chk32(port_of(x) == 2'h1 ? bdata : pdata, d);
      chk32({28'h0, port_of(x) == 2'h1 ? bstrb : pstrb}, {28'h0, s});
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    {m_if.awvalid, m_if.wvalid, m_if.arvalid, m_if.bready, m_if.rready} = '0;
    {m_if.awaddr, m_if.araddr, m_if.wdata, m_if.wstrb, m_if.awprot, m_if.arprot} = '0;
    repeat (10) @(negedge clk_i);
    rst_i = 1'b0;
    for (int i = 0; i < 16; i++)
      xfer(1'b0, 24'(4 * i), 32'h0, 4'h0);
    // Write first, then read back the same offset
    for (int i = 0; i < 16; i++)
      xfer(!i[0], 24'(4 * (i / 2)), $random(seed), 4'hf);
    for (int i = 0; i < 4; i++)
      xfer(i[0], (i < 2) ? 24'h000040 : 24'h0000fc, 32'h0, 4'hf);
    for (int i = 0; i < 40; i++)
    begin
      r = $random(seed);
      a = r[31] ? {8'h00, 16'h0100 + (r[15:0] & 16'hfefc)} :
                  {8'h01 + (r[23:16] & 8'hfe), r[15:0] & 16'hfffc};
      xfer(r[30], a, $random(seed), r[27:24]);
    end
    for (int i = 0; i < 8; i++)
      xfer(i[0], edges[i / 2], $random(seed), 4'h5);
    @(negedge clk_i);
    rst_i = 1'b1;
    repeat (2) @(negedge clk_i);
    rst_i = 1'b0;
    chk2({busy_o, lbusy}, 2'h0);
    chk2(last_port_o, 2'h0);
    xfer(1'b0, 24'h000000, 32'h0, 4'h0);
    results();
  end
endmodule
